// ==== design/reset_supervisor_regs.vh ====
// Constants for the reset, watchdog and supply supervisor
// What this block does
// R1: Reset level zero returns power-on, hardware and switch-off class registers to defaults.
// R2: Reset level one reinitialises hardware and switch-off classes, keeps power-on class.
// R3: Reset level two reinitialises only the switch-off class; the code reinitialises every register except the POR class, as at level one.
// R4: Power-on reset is raised on the move from no-supply into backup.
// R5: OFF request with hardware reset applies level one and runs the shutdown sequence.
// R6: OFF request without hardware reset applies level two and runs the shutdown sequence.
// R7: Warm restart pin runs off-to-active from ACTIVE or SLEEP, ends in ACTIVE.
// R8: Each regulator reloads or keeps its level on warm restart per its select bit.
// R9: External reset input gates power-on requests and is a programmable switch-off event.
// R10: Periodic watchdog raises its interrupt when the counter equals one.
// R11: Periodic watchdog shuts down at N only if the interrupt was not cleared.
// R12: Clearing does not reset the periodic counter; it wraps to zero after N.
// R13: Watchdog counter held at zero while processor reset output is low.
// R14: Interrupt mode: any source restarts the counter; shutdown if line still high at N.
// R15: Host clears sources within N; then the count is discarded and no shutdown.
// R16: Watchdog is disabled after reset until software enables it.
// R17: Stay in no-supply below power-on threshold; go to backup above it.
// R18: Backup to OFF above low threshold; ACTIVE, SLEEP or OFF to backup below it.
// R19: Active-to-backup shuts regulators except RTC at once with crystal, else after 180 us.
// R20: OFF to ACTIVE allowed only while the monitor reports supply above startup threshold.
// R21: Monitor comparator disabled automatically after start-up; software may re-enable it.
// R22: Wait 125 us after one monitor interrupt before raising another.
// R23: Watchdog enable, mode and period N are software settings read by the counter.
`ifndef RESET_SUPERVISOR_REGS_VH
`define RESET_SUPERVISOR_REGS_VH
`define LVL_POR 2'h0
`define LVL_HW 2'h1
`define LVL_SWO 2'h2
`define LVL_NONE 2'h3
`define WD_PERIOD_RST 8'h0A
`define WD_CTRL_RST 2'h0
`define MON_THR_RST 8'h00
`define CLK_MHZ 100
`define DEGLITCH_US 180
`define DEGLITCH_CYC (`DEGLITCH_US * `CLK_MHZ)
`define DEBOUNCE_US 125
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
`define SEQ_CYC 16'h0010
`endif

// ==== design/reset_supervisor.v ====
// Reset-level, warm restart, watchdog and supply supervisor state machine
`timescale 1ns/1ps
`include "reset_supervisor_regs.vh"
module reset_supervisor #(
   parameter NREG = 4,
   parameter WD_W = 8,
   parameter DEGLITCH_CYC = `DEGLITCH_CYC,
   parameter DEBOUNCE_CYC = `DEBOUNCE_CYC
)(
   // Clock and reset
   input wire ref_clk,
   input wire resetn,
   // Supply comparators
   input wire por_ok,
   input wire main_supply_input,
   input wire startup_ok,
   input wire monitor_raw,
   input wire xtal_present,
   // Requests
   input wire on_req,
   input wire off_req,
   input wire off_hardware_reset_level_cfg,
   input wire sleep_req,
   input wire warm_restart_pin_n,
   input wire ext_reset_in,
   input wire ext_reset_cold,
   input wire int_line,
   input wire wd_int_clear,
   // Software settings
   input wire wd_enable,
   input wire wd_int_mode,
   input wire [WD_W-1:0] wd_period,
   input wire wd_write,
   input wire [7:0] mon_thr_wdata,
   input wire mon_write,
   input wire mon_en_set,
   input wire [NREG-1:0] wr_select,
   input wire [NREG*8-1:0] nv_level,
   input wire [NREG*8-1:0] sw_level,
   input wire [NREG-1:0] sw_level_we,
   // Outputs
   output reg [5:0] state_ff,
   output reg [1:0] reset_level_ff,
   output reg reset_pulse_ff,
   output reg proc_reset_n_ff,
   output reg regulators_on_ff,
   output reg rtc_regulator_ff,
   output reg wd_int_ff,
   output reg wd_shutdown_ff,
   output reg mon_en_ff,
   output reg [7:0] mon_thr_ff,
   output reg mon_int_ff,
   output reg [NREG*8-1:0] reg_level_ff,
   output reg [1:0] wd_ctrl_ff,
   output reg [WD_W-1:0] wd_period_ff
);
   localparam S_NOSUP = 6'h01;
   localparam S_BACKUP = 6'h02;
   localparam S_OFF = 6'h04;
   localparam S_SEQ = 6'h08;
   localparam S_ACTIVE = 6'h10;
   localparam S_SLEEP = 6'h20;

   reg [5:0] nxt_state;
   reg [1:0] nxt_level;
   reg [15:0] seq_cnt_ff;
   reg [31:0] deg_cnt_ff;
   reg [31:0] deb_cnt_ff;
   reg [WD_W-1:0] wd_cnt_ff;
   reg wd_cleared_ff;
   reg int_line_d_ff;
   reg warm_d_ff;
   reg poweron_ff;
   reg warm_run_ff;
   reg mon_d_ff;
   reg off_seq_ff;
   wire lo = !main_supply_input;
   wire wd_shut;
   wire warm_edge = warm_d_ff && !warm_restart_pin_n;
   wire off_event = off_req | (ext_reset_in & ~ext_reset_cold);
   wire cold_event = ext_reset_in & ext_reset_cold;
   integer i;

   // Next state; supply loss overrides everything
   always @*
   begin
      nxt_state = state_ff;
      nxt_level = `LVL_NONE;
      case (state_ff)
         S_NOSUP:
            if (por_ok)
            begin
               nxt_state = S_BACKUP; // R17
               nxt_level = `LVL_POR; // R4
            end
         S_BACKUP:
            if (!por_ok)
               nxt_state = S_NOSUP; // R17
            else if (main_supply_input)
               nxt_state = S_OFF; // R18
         S_OFF:
            if (lo)
               nxt_state = S_BACKUP; // R18
            else if (on_req && !ext_reset_in && startup_ok) // R9 R20
               nxt_state = S_SEQ;
         S_SEQ:
            if (lo)
               nxt_state = S_BACKUP;
            else if (seq_cnt_ff == `SEQ_CYC)
               nxt_state = off_seq_ff ? S_OFF : S_ACTIVE;
         S_ACTIVE, S_SLEEP:
            if (lo)
            begin
               if (xtal_present || deg_cnt_ff >= DEGLITCH_CYC) // R19
                  nxt_state = S_BACKUP; // R18
            end
            else if (off_event || wd_shut || cold_event)
            begin
               nxt_state = S_SEQ; // R5 R6
               nxt_level = (off_hardware_reset_level_cfg || cold_event) ? `LVL_HW : `LVL_SWO; // R5 R6 R9
            end
            else if (warm_edge)
               nxt_state = S_SEQ; // R7
            else if (state_ff == S_ACTIVE && sleep_req)
               nxt_state = S_SLEEP;
            else if (state_ff == S_SLEEP && !sleep_req)
               nxt_state = S_ACTIVE;
         default:
            nxt_state = S_NOSUP;
      endcase
   end

   // Watchdog shutdown: periodic mode needs an uncleared period, interrupt mode a live line
   assign wd_shut = wd_ctrl_ff[0] && proc_reset_n_ff && (wd_cnt_ff == wd_period_ff) &&
      (wd_ctrl_ff[1] ? int_line : !wd_cleared_ff); // R11 R14

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff <= S_NOSUP;
         reset_level_ff <= `LVL_NONE;
         reset_pulse_ff <= 1'b0;
         proc_reset_n_ff <= 1'b0;
         regulators_on_ff <= 1'b0;
         rtc_regulator_ff <= 1'b0;
         seq_cnt_ff <= 16'h0000;
         deg_cnt_ff <= 32'h00000000;
         off_seq_ff <= 1'b0;
         warm_run_ff <= 1'b0;
         warm_d_ff <= 1'b1;
         poweron_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         warm_d_ff <= warm_restart_pin_n;
         reset_pulse_ff <= nxt_level != `LVL_NONE;
         if (nxt_level != `LVL_NONE)
            reset_level_ff <= nxt_level;
         rtc_regulator_ff <= state_ff != S_NOSUP;
         deg_cnt_ff <= (lo && (state_ff == S_ACTIVE || state_ff == S_SLEEP)) ? deg_cnt_ff + 32'h1 : 32'h0;
         poweron_ff <= 1'b0;
         if (nxt_state == S_SEQ && state_ff != S_SEQ)
         begin
            seq_cnt_ff <= 16'h0000;
            off_seq_ff <= (state_ff != S_OFF) && !warm_edge;
            warm_run_ff <= (state_ff != S_OFF) && warm_edge; // R7
            proc_reset_n_ff <= 1'b0;
         end
         else if (state_ff == S_SEQ)
            seq_cnt_ff <= seq_cnt_ff + 16'h1;
         if (nxt_state == S_ACTIVE && state_ff == S_SEQ)
         begin
            proc_reset_n_ff <= 1'b1;
            regulators_on_ff <= 1'b1;
            poweron_ff <= 1'b1;
         end
         // All but the RTC regulator drop together
         if (nxt_state == S_BACKUP || nxt_state == S_OFF)
         begin
            regulators_on_ff <= 1'b0; // R19
            proc_reset_n_ff <= 1'b0;
         end
      end
   end

   // Register classes: POR class cleared only at level zero, all other registers at levels zero, one and two
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mon_thr_ff <= `MON_THR_RST;
         mon_en_ff <= 1'b1;
         wd_ctrl_ff <= `WD_CTRL_RST; // R16
         wd_period_ff <= `WD_PERIOD_RST;
         reg_level_ff <= {NREG*8{1'b0}};
      end
      else
      begin
         if (reset_pulse_ff && reset_level_ff == `LVL_POR)
            mon_thr_ff <= `MON_THR_RST; // R1
         else if (mon_write)
            mon_thr_ff <= mon_thr_wdata; // R21
         if (reset_pulse_ff && reset_level_ff != `LVL_NONE) // R1 R2 R3
         begin
            wd_ctrl_ff <= `WD_CTRL_RST; // R16
            wd_period_ff <= `WD_PERIOD_RST;
            mon_en_ff <= 1'b1;
            reg_level_ff <= nv_level;
         end
         else
         begin
            if (wd_write)
            begin
               wd_ctrl_ff <= {wd_int_mode, wd_enable}; // R23
               wd_period_ff <= wd_period;
            end
            if (poweron_ff)
               mon_en_ff <= 1'b0; // R21
            else if (mon_en_set)
               mon_en_ff <= 1'b1;
            for (i = 0; i < NREG; i = i + 1)
            begin
               if (poweron_ff && warm_run_ff)
               begin
                  if (wr_select[i])
                     reg_level_ff[i*8 +: 8] <= nv_level[i*8 +: 8]; // R8
               end
               else if (sw_level_we[i])
                  reg_level_ff[i*8 +: 8] <= sw_level[i*8 +: 8];
            end
         end
      end
   end

   // Watchdog counter and interrupt
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wd_cnt_ff <= {WD_W{1'b0}};
         wd_int_ff <= 1'b0;
         wd_cleared_ff <= 1'b0;
         wd_shutdown_ff <= 1'b0;
         int_line_d_ff <= 1'b0;
      end
      else
      begin
         int_line_d_ff <= int_line;
         wd_shutdown_ff <= wd_shut && state_ff != S_SEQ;
         if (!proc_reset_n_ff || !wd_ctrl_ff[0])
         begin
            wd_cnt_ff <= {WD_W{1'b0}}; // R13
            wd_int_ff <= 1'b0;
            wd_cleared_ff <= 1'b0;
         end
         else if (wd_ctrl_ff[1])
         begin
            wd_int_ff <= 1'b0;
            if (int_line && !int_line_d_ff)
               wd_cnt_ff <= {{WD_W-1{1'b0}}, 1'b1}; // R14
            else if (!int_line)
               wd_cnt_ff <= {WD_W{1'b0}}; // R15
            else if (wd_cnt_ff != wd_period_ff)
               wd_cnt_ff <= wd_cnt_ff + 1'b1;
         end
         else
         begin
            wd_cnt_ff <= (wd_cnt_ff >= wd_period_ff) ? {WD_W{1'b0}} : wd_cnt_ff + 1'b1; // R12
            if (wd_cnt_ff == {{WD_W-1{1'b0}}, 1'b1})
            begin
               wd_int_ff <= 1'b1; // R10
               wd_cleared_ff <= 1'b0;
            end
            else if (wd_int_clear)
            begin
               wd_int_ff <= 1'b0; // R12
               wd_cleared_ff <= 1'b1;
            end
         end
      end
   end

   // Monitor interrupt with dead time, since the comparator has no hysteresis
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         mon_d_ff <= 1'b0;
         mon_int_ff <= 1'b0;
         deb_cnt_ff <= 32'h00000000;
      end
      else
      begin
         mon_d_ff <= monitor_raw;
         mon_int_ff <= 1'b0;
         if (deb_cnt_ff != 32'h0)
            deb_cnt_ff <= deb_cnt_ff - 32'h1;
         else if (mon_en_ff && monitor_raw != mon_d_ff)
         begin
            mon_int_ff <= 1'b1;
            deb_cnt_ff <= DEBOUNCE_CYC; // R22
         end
      end
   end
endmodule

// ==== bench/reset_supervisor_asserts.sv ====
// Concurrent checks on the supervisor ports
`timescale 1ns/1ps
module reset_supervisor_asserts #(
   parameter NREG = 4,
   parameter WD_W = 8,
   parameter DEGLITCH_CYC = 4,
   parameter DEBOUNCE_CYC = 4
)(
   // Clock and reset
   input wire ref_clk,
   input wire resetn,
   // Inputs watched
   input wire por_ok,
   input wire main_supply_input,
   input wire startup_ok,
   input wire xtal_present,
   input wire ext_reset_in,
   input wire warm_restart_pin_n,
   // Outputs watched
   input wire [5:0] state_ff,
   input wire [1:0] reset_level_ff,
   input wire reset_pulse_ff,
   input wire proc_reset_n_ff,
   input wire regulators_on_ff,
   input wire wd_int_ff,
   input wire mon_int_ff,
   input wire [1:0] wd_ctrl_ff
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Sequence state lasts 17 cycles, split because repetitions stay short
   sequence seq_hold8;
      (state_ff == 6'h08) [*8];
   endsequence
   sequence seq_run;
      seq_hold8 ##1 seq_hold8 ##1 (state_ff == 6'h08) ##1 (state_ff != 6'h08);
   endsequence
   AST_SEQ_LEN: assert property ($rose(state_ff == 6'h08) |-> seq_run) else $error("sequence length wrong");
   AST_SEQ_RST: assert property (state_ff == 6'h08 |-> !proc_reset_n_ff) else $error("reset out high in seq");
   AST_POR: assert property (state_ff == 6'h01 && por_ok |=> state_ff == 6'h02 && reset_pulse_ff
      && reset_level_ff == 2'h0) else $error("no power-on reset");
   AST_NOSUP: assert property (state_ff == 6'h01 && !por_ok |=> state_ff == 6'h01) else $error("left no-supply");
   AST_UP: assert property (state_ff == 6'h02 && por_ok && main_supply_input |=> state_ff == 6'h04)
      else $error("backup not left");
   AST_GATE: assert property (state_ff == 6'h04 && main_supply_input && (ext_reset_in || !startup_ok)
      |=> state_ff == 6'h04) else $error("gated start ran");
   AST_XTAL: assert property (state_ff == 6'h10 && !main_supply_input && xtal_present |=> !regulators_on_ff)
      else $error("regulators not cut");
   AST_WARM: assert property (state_ff == 6'h10 && $fell(warm_restart_pin_n) |=> state_ff == 6'h08)
      else $error("warm restart ignored");
   AST_MON_GAP: assert property (mon_int_ff |=> !mon_int_ff [*4]) else $error("monitor too soon");
   AST_WD_OFF: assert property (!wd_ctrl_ff[0] && $past(!wd_ctrl_ff[0]) |-> !wd_int_ff)
      else $error("watchdog irq while off");
endmodule

// ==== bench/host_model.sv ====
// Host processor model: clears watchdog irq and re-arms the monitor
`timescale 1ns/1ps
module host_model (
   // Clock and reset
   input wire ref_clk,
   input wire resetn,
   // From the supervisor
   input wire proc_reset_n_ff,
   input wire wd_int_ff,
   input wire clear_on,
   // To the supervisor
   output reg wd_int_clear,
   output reg mon_write,
   output reg mon_en_set,
   output wire [7:0] mon_thr_wdata
);
   reg [2:0] up_ff;
   assign mon_thr_wdata = 8'h5A;
   // Waits a few cycles so the automatic monitor shut-off lands first
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         up_ff <= 3'h0;
         wd_int_clear <= 1'b0;
         mon_write <= 1'b0;
         mon_en_set <= 1'b0;
      end
      else
      begin
         up_ff <= !proc_reset_n_ff ? 3'h0 : (up_ff == 3'h7 ? up_ff : up_ff + 3'h1);
         mon_write <= (up_ff == 3'h3);
         mon_en_set <= (up_ff == 3'h4);
         wd_int_clear <= clear_on && wd_int_ff && !wd_int_clear;
      end
   end
endmodule

// ==== bench/reset_supervisor_tb_top.sv ====
// Directed testbench for the reset, watchdog and supply supervisor
`timescale 1ns/1ps
`include "reset_supervisor_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module reset_supervisor_tb_top;
   reg ref_clk = 0, resetn = 0, por_ok = 0, main_supply_input = 0, startup_ok = 0, monitor_raw = 0;
   reg xtal_present = 0, on_req = 0, off_req = 0, off_hardware_reset_level_cfg = 0, sleep_req = 0, warm_restart_pin_n = 1;
   reg ext_reset_in = 0, ext_reset_cold = 0, int_line = 0, wd_enable = 0, wd_int_mode = 0, wd_write = 0;
   reg clear_on = 1;
   reg [7:0] wd_period = 8'h00;
   reg [3:0] wr_select = 4'h0, sw_level_we = 4'h0;
   reg [31:0] nv_level = 32'h0, sw_level = 32'h0;
   wire wd_int_clear, mon_write, mon_en_set, reset_pulse_ff, proc_reset_n_ff, regulators_on_ff, rtc_regulator_ff;
   wire wd_int_ff, wd_shutdown_ff, mon_en_ff, mon_int_ff;
   wire [7:0] mon_thr_wdata, mon_thr_ff, wd_period_ff;
   wire [5:0] state_ff;
   wire [1:0] reset_level_ff, wd_ctrl_ff;
   wire [31:0] reg_level_ff;
   int failures = 0, total_checks = 0, irq_cnt = 0, mon_cnt = 0;
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (wd_int_ff === 1'b1 && !wd_int_clear) irq_cnt++;
   always @(posedge ref_clk) if (mon_int_ff === 1'b1) mon_cnt++;
   reset_supervisor #(.NREG(4), .WD_W(8), .DEGLITCH_CYC(4), .DEBOUNCE_CYC(4)) i_reset_supervisor (
      .ref_clk(ref_clk), .resetn(resetn), .por_ok(por_ok), .main_supply_input(main_supply_input),
      .startup_ok(startup_ok), .monitor_raw(monitor_raw), .xtal_present(xtal_present), .on_req(on_req),
      .off_req(off_req), .off_hardware_reset_level_cfg(off_hardware_reset_level_cfg), .sleep_req(sleep_req),
      .warm_restart_pin_n(warm_restart_pin_n), .ext_reset_in(ext_reset_in), .ext_reset_cold(ext_reset_cold),
      .int_line(int_line), .wd_int_clear(wd_int_clear), .wd_enable(wd_enable), .wd_int_mode(wd_int_mode),
      .wd_period(wd_period), .wd_write(wd_write), .mon_thr_wdata(mon_thr_wdata), .mon_write(mon_write),
      .mon_en_set(mon_en_set), .wr_select(wr_select), .nv_level(nv_level), .sw_level(sw_level),
      .sw_level_we(sw_level_we), .state_ff(state_ff), .reset_level_ff(reset_level_ff),
      .reset_pulse_ff(reset_pulse_ff), .proc_reset_n_ff(proc_reset_n_ff), .regulators_on_ff(regulators_on_ff),
      .rtc_regulator_ff(rtc_regulator_ff), .wd_int_ff(wd_int_ff), .wd_shutdown_ff(wd_shutdown_ff),
      .mon_en_ff(mon_en_ff), .mon_thr_ff(mon_thr_ff), .mon_int_ff(mon_int_ff), .reg_level_ff(reg_level_ff),
      .wd_ctrl_ff(wd_ctrl_ff), .wd_period_ff(wd_period_ff));
   host_model i_host_model (.ref_clk(ref_clk), .resetn(resetn), .proc_reset_n_ff(proc_reset_n_ff),
      .wd_int_ff(wd_int_ff), .clear_on(clear_on), .wd_int_clear(wd_int_clear), .mon_write(mon_write),
      .mon_en_set(mon_en_set), .mon_thr_wdata(mon_thr_wdata));
   task go(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Bounded waits; a miss shows up as a mismatch
   task wait_st(input [5:0] s);
      int i;
      for (i = 0; i < 300 && state_ff !== s; i++) begin go(1); #1; end
      `CHK(state_ff, s)
   endtask
   task wait_lvl(input [1:0] l);
      int i;
      for (i = 0; i < 300 && reset_pulse_ff !== 1'b1; i++) begin go(1); #1; end
      `CHK(reset_level_ff, l)
   endtask
   task test_done;
      if (failures == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      failures++;
      test_done;
   end
   initial
   begin
      go(20); resetn <= 1'b1; #1;
      `CHK({state_ff, reset_level_ff, mon_en_ff, wd_period_ff, wd_ctrl_ff}, {6'h01, `LVL_NONE, 1'b1, 8'h0A, 2'h0})
      go(1); por_ok <= 1'b1; go(1); #1;
      `CHK({state_ff, reset_pulse_ff, reset_level_ff}, {6'h02, 1'b1, `LVL_POR})
      go(1); main_supply_input <= 1'b1; go(1); #1;
      `CHK({state_ff, rtc_regulator_ff}, {6'h04, 1'b1})
      go(1); ext_reset_in <= 1'b1; on_req <= 1'b1; startup_ok <= 1'b1; go(4); #1;
      `CHK(state_ff, 6'h04)
      go(1); ext_reset_in <= 1'b0; startup_ok <= 1'b0; go(4); #1;
      `CHK(state_ff, 6'h04)
      go(1); startup_ok <= 1'b1; wait_st(6'h10);
      go(1); on_req <= 1'b0; #1;
      `CHK({proc_reset_n_ff, mon_en_ff}, 2'b10)
      go(1); wd_enable <= 1'b1; wd_period <= 8'h06; wd_write <= 1'b1; go(1); wd_write <= 1'b0; go(1); #1;
      `CHK({wd_ctrl_ff, wd_period_ff}, {2'h1, 8'h06})
      go(40); #1;
      `CHK({state_ff, irq_cnt > 2}, {6'h10, 1'b1})
      go(1); clear_on <= 1'b0; wait_lvl(`LVL_SWO);
      `CHK(wd_shutdown_ff, 1'b1)
      wait_st(6'h04);
      go(1); wr_select <= 4'h1; nv_level <= 32'h44332211; on_req <= 1'b1; wait_st(6'h10);
      go(1); on_req <= 1'b0; sw_level <= 32'hAAAAAAAA; sw_level_we <= 4'hF; go(1); sw_level_we <= 4'h0;
      go(1); warm_restart_pin_n <= 1'b0; go(2); warm_restart_pin_n <= 1'b1; wait_st(6'h08);
      wait_st(6'h10);
      go(1); #1;
      `CHK(reg_level_ff, 32'hAAAAAA11)
      go(1); clear_on <= 1'b1; off_hardware_reset_level_cfg <= 1'b1; off_req <= 1'b1; wait_lvl(`LVL_HW);
      go(1); off_req <= 1'b0; go(2); #1;
      `CHK({mon_thr_ff, wd_ctrl_ff, reg_level_ff}, {8'h5A, 2'h0, 32'h44332211})
      wait_st(6'h04);
      repeat (12) begin go(1); monitor_raw <= ~monitor_raw; end
      go(1); on_req <= 1'b1; wait_st(6'h10);
      `CHK(mon_cnt, 3)
      go(1); on_req <= 1'b0; off_hardware_reset_level_cfg <= 1'b0; sleep_req <= 1'b1; go(2); #1;
      `CHK(state_ff, 6'h20)
      go(1); sleep_req <= 1'b0; ext_reset_in <= 1'b1; ext_reset_cold <= 1'b1; wait_lvl(`LVL_HW);
      go(1); ext_reset_in <= 1'b0; ext_reset_cold <= 1'b0; wait_st(6'h04);
      go(1); on_req <= 1'b1; wait_st(6'h10);
      go(1); on_req <= 1'b0; wd_int_mode <= 1'b1; wd_write <= 1'b1;
      go(1); wd_write <= 1'b0; int_line <= 1'b1; go(3); int_line <= 1'b0; go(12); #1;
      `CHK({state_ff, wd_shutdown_ff}, {6'h10, 1'b0})
      go(1); int_line <= 1'b1; go(7); #1;
      `CHK({reset_pulse_ff, reset_level_ff, wd_shutdown_ff}, {1'b1, `LVL_SWO, 1'b1})
      go(1); int_line <= 1'b0; wait_st(6'h04);
      go(1); on_req <= 1'b1; wait_st(6'h10);
      go(1); main_supply_input <= 1'b0; go(4); #1;
      `CHK({state_ff, regulators_on_ff}, {6'h10, 1'b1})
      go(1); #1;
      `CHK({state_ff, regulators_on_ff, rtc_regulator_ff}, {6'h02, 1'b0, 1'b1})
      go(1); main_supply_input <= 1'b1; xtal_present <= 1'b1; wait_st(6'h10);
      go(1); main_supply_input <= 1'b0; go(1); #1;
      `CHK({regulators_on_ff, rtc_regulator_ff}, 2'b01)
      wait_st(6'h02);
      test_done;
   end
endmodule
bind reset_supervisor reset_supervisor_asserts #(.NREG(NREG), .WD_W(WD_W), .DEGLITCH_CYC(DEGLITCH_CYC),
   .DEBOUNCE_CYC(DEBOUNCE_CYC)) i_reset_supervisor_asserts (.ref_clk(ref_clk), .resetn(resetn),
   .por_ok(por_ok), .main_supply_input(main_supply_input), .startup_ok(startup_ok), .xtal_present(xtal_present),
   .ext_reset_in(ext_reset_in), .warm_restart_pin_n(warm_restart_pin_n), .state_ff(state_ff),
   .reset_level_ff(reset_level_ff), .reset_pulse_ff(reset_pulse_ff), .proc_reset_n_ff(proc_reset_n_ff),
   .regulators_on_ff(regulators_on_ff), .wd_int_ff(wd_int_ff), .mon_int_ff(mon_int_ff), .wd_ctrl_ff(wd_ctrl_ff));
